// file: chan_mask_pkg.sv
// Constants for the channel disable mask and accumulation tally block.
// Assumes a byte-wide register port decoded by the serial-link front end.
// Contract
// - A channel whose mask bit is one is left out of conversion.
// - Mask applies to round-robin and single-shot sampling alike.
// - Auto-increment pointer skips disabled channel addresses unless no-skip is set; with all four masked it skips at most four and can land on a disabled one.
// - Mask bit 3 is channel 1, bit 0 is channel 4.
// - Sampling mode field in control bits 15:12 selects burst and fast.
// - Mask resets by fitted channel count: 0000, 0001, 0011, 0111.
// - Control bits 3:0 always read as zero.
// - 32-bit tally counts each power result summed; zero at power-on.
// - Refresh latches tally and clears accumulation; readable after 1 ms.
package chan_mask_pkg;
  localparam logic [7:0] OFF_REFRESH = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h01;
  localparam logic [7:0] OFF_TALLY = 8'h02;
  localparam logic [7:0] OFF_CH_FIRST = 8'h03; // First per-channel result address
  localparam logic [7:0] OFF_CH_LAST = 8'h1A; // Last per-channel result address
  localparam int MODE_LSB = 12;
  localparam int ALERT2_LSB = 10;
  localparam int ALERT1_LSB = 8;
  localparam int MASK_LSB = 4;
  localparam logic [15:0] CTRL_RESET_BASE = 16'h0700;
  localparam logic [3:0] MODE_SINGLE = 4'h8;
  localparam logic [3:0] MODE_SINGLE8 = 4'h9;
  localparam logic [3:0] MODE_FAST = 4'hA;
  localparam logic [3:0] MODE_BURST = 4'hB;
  localparam logic [3:0] MODE_SLEEP = 4'hF;
  localparam int REFRESH_SETTLE_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_SETTLE_CYC = REFRESH_SETTLE_NS / CLK_PERIOD_NS;
  localparam int NCHAN = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_READY = 3'b100
  } refresh_state_t;
endpackage

// file: tally_store.sv
`timescale 1ns/1ps
// Small memory holding four tally snapshot bytes, registered read data.
// Assumes writes and reads on the common mclk.
module tally_store (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [31:0] wr_word,
  // Read side
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_byte
);
  logic [7:0] mem_q [4];
  logic [7:0] rd_q;

  // Whole snapshot is written at once so all bytes stay coherent
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= 8'h00;
      end
      rd_q <= 8'h00;
    end else begin
      if (wr_en) begin
        for (int i = 0; i < 4; i++) begin
          mem_q[i] <= wr_word[8*i +: 8];
        end
      end
      rd_q <= mem_q[rd_idx];
    end
  end

  assign rd_byte = rd_q;
endmodule

// file: chan_mask_regs.sv
`timescale 1ns/1ps
// Control register, channel mask and accumulation tally for the power monitor.
// Assumes the serial-link front end delivers decoded byte writes, reads and
// pointer steps, all synchronous to mclk.
module chan_mask_regs
  import chan_mask_pkg::*;
#(
  parameter logic [3:0] FITTED_MASK = 4'h0, // Reset mask for the fitted channel count
  parameter int SETTLE_CYC = REFRESH_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register byte port from the serial link
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [1:0] byte_sel,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Auto-increment pointer step
  input wire logic ptr_step,
  input wire logic no_skip,
  output logic [7:0] ptr_next,
  // Converter side
  input wire logic power_summed,
  output logic [3:0] chan_active,
  output logic [3:0] sample_mode,
  output logic fast_sel,
  output logic acc_clear,
  output logic data_ready
);
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] tally_q, tally_d;
  logic [7:0] rdata_q, rdata_d;
  logic tally_rd_q, tally_rd_d;
  logic [7:0] ptr_q, ptr_d;
  logic [3:0] act_q, act_d;
  logic [3:0] mode_q, mode_d;
  logic fast_q, fast_d;
  logic clr_q, clr_d;
  logic rdy_q, rdy_d;
  logic [19:0] cnt_q, cnt_d;
  refresh_state_t st_q, st_d;
  logic [7:0] snap_byte;
  logic refresh_hit;

  assign refresh_hit = wr_stb && addr == OFF_REFRESH;

  tally_store u_store (
    .mclk(mclk),
    .arst_n(arst_n),
    .wr_en(refresh_hit),
    .wr_word(tally_q),
    .rd_idx(byte_sel),
    .rd_byte(snap_byte)
  );

  // Channel index of a result address, 0 for channel 1
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFF_CH_FIRST;
    chan_of = rel[1:0];
  endfunction

  // Mask bit 3 is channel 1, so mask index is reversed
  function automatic logic chan_off(input logic [15:0] c, input logic [1:0] ch);
    chan_off = c[MASK_LSB + 3 - int'(ch)];
  endfunction

  // Register writes, tally counting and read mux
  always_comb begin
    ctrl_d = ctrl_q;
    tally_d = tally_q;
    rdata_d = rdata_q;
    if (wr_stb && addr == OFF_CTRL) begin
      if (byte_sel == 2'd1) begin
        ctrl_d[15:8] = wdata;
      end else if (byte_sel == 2'd0) begin
        ctrl_d[7:0] = {wdata[7:4], 4'h0};
      end
    end
    // Refresh restarts counting, a result in the same cycle counts as one
    if (refresh_hit) begin
      tally_d = {31'h0, power_summed};
    end else if (power_summed) begin
      tally_d = tally_q + 32'h1;
    end else if (wr_stb && addr == OFF_TALLY) begin
      tally_d[8*byte_sel +: 8] = wdata;
    end
    if (rd_stb) begin
      case (addr)
        OFF_CTRL: rdata_d = byte_sel[0] ? ctrl_q[15:8] : {ctrl_q[7:4], 4'h0};
        default: rdata_d = 8'h00;
      endcase
    end
    // Snapshot byte lands two cycles after the request and stands until the next read
    tally_rd_d = rd_stb && addr == OFF_TALLY;
    if (tally_rd_q) begin
      rdata_d = snap_byte;
    end
  end

  // Pointer skips up to four addresses of disabled channels in the result block
  always_comb begin
    ptr_d = ptr_q;
    if (wr_stb && addr != OFF_REFRESH) begin
      ptr_d = addr;
    end else if (ptr_step) begin
      ptr_d = ptr_q + 8'h01;
      for (int k = 0; k < NCHAN; k++) begin
        if (!no_skip && ptr_d >= OFF_CH_FIRST && ptr_d <= OFF_CH_LAST
            && chan_off(ctrl_q, chan_of(ptr_d))) begin
          ptr_d = ptr_d + 8'h01;
        end
      end
    end
  end

  // Converter-facing decode of mask and mode
  always_comb begin
    mode_d = ctrl_q[MODE_LSB +: 4];
    fast_d = mode_d == MODE_FAST || mode_d == MODE_BURST;
    act_d = 4'h0;
    if (mode_d != MODE_SLEEP) begin
      // Same mask in continuous and single-shot modes
      for (int c = 0; c < NCHAN; c++) begin
        act_d[c] = !ctrl_q[MASK_LSB + 3 - c];
      end
    end
  end

  // Refresh settle sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    clr_d = refresh_hit;
    rdy_d = rdy_q;
    case (st_q)
      ST_IDLE, ST_READY: begin
        if (refresh_hit) begin
          st_d = ST_SETTLE;
          cnt_d = 20'(SETTLE_CYC - 1);
          rdy_d = 1'b0;
        end
      end
      ST_SETTLE: begin
        if (refresh_hit) begin
          cnt_d = 20'(SETTLE_CYC - 1);
        end else if (cnt_q == 20'h0) begin
          st_d = ST_READY;
          rdy_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 20'h1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET_BASE | {8'h00, FITTED_MASK, 4'h0};
      tally_q <= 32'h0;
      rdata_q <= 8'h00;
      tally_rd_q <= 1'b0;
      ptr_q <= 8'h00;
      act_q <= 4'h0;
      mode_q <= 4'h0;
      fast_q <= 1'b0;
      clr_q <= 1'b0;
      rdy_q <= 1'b0;
      cnt_q <= 20'h0;
      st_q <= ST_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      tally_q <= tally_d;
      rdata_q <= rdata_d;
      tally_rd_q <= tally_rd_d;
      ptr_q <= ptr_d;
      act_q <= act_d;
      mode_q <= mode_d;
      fast_q <= fast_d;
      clr_q <= clr_d;
      rdy_q <= rdy_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
    end
  end

  // Outputs straight from flops; tally reads show the refresh snapshot
  assign rdata = rdata_q;
  assign ptr_next = ptr_q;
  assign chan_active = act_q;
  assign sample_mode = mode_q;
  assign fast_sel = fast_q;
  assign acc_clear = clr_q;
  assign data_ready = rdy_q;

  // Checks
  AST_MASK_EXCLUDE: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrl_q[MASK_LSB + 3] && mode_d != MODE_SLEEP |=> !chan_active[0])
    else $error("disabled channel 1 still active");
  AST_MASK_ORDER: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrl_q[7:4] == 4'b0100 && mode_d != MODE_SLEEP |=> chan_active == 4'b1101)
    else $error("mask bit order wrong");
  // Active bits run channel 1 first, mask bits channel 1 last
  AST_SINGLE_MASK: assert property (@(posedge mclk) disable iff (!arst_n)
    mode_d == MODE_SINGLE |=> chan_active == ~{$past(ctrl_q[4]), $past(ctrl_q[5]),
    $past(ctrl_q[6]), $past(ctrl_q[7])})
    else $error("single shot ignores mask");
  AST_LOW_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrl_q[3:0] == 4'h0)
    else $error("control low nibble not zero");
  AST_TALLY_INC: assert property (@(posedge mclk) disable iff (!arst_n)
    power_summed && !refresh_hit |=> tally_q == $past(tally_q) + 32'h1)
    else $error("tally did not count");
  // A second refresh right behind the first may keep the clear high
  AST_REFRESH_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
    refresh_hit |=> acc_clear ##1 (!acc_clear || $past(refresh_hit)))
    else $error("refresh clear pulse wrong");
  AST_FAST_MODE: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrl_q[15:12] == MODE_BURST |=> fast_sel)
    else $error("burst not flagged fast");
  AST_SKIP: assert property (@(posedge mclk) disable iff (!arst_n)
    ptr_step && !wr_stb && !no_skip |=> ptr_next < OFF_CH_FIRST || ptr_next > OFF_CH_LAST
    || !chan_off($past(ctrl_q), chan_of(ptr_next)))
    else $error("pointer landed on disabled channel");
  AST_NOSKIP: assert property (@(posedge mclk) disable iff (!arst_n)
    ptr_step && !wr_stb && no_skip |=> ptr_next == $past(ptr_next) + 8'h01)
    else $error("pointer skipped with no-skip set");
endmodule

// file: host_link_model.sv
// Host side of the decoded register byte port: write and read tasks.
// Assumes one mclk shared with the register block; requests start on an edge.
`timescale 1ns/1ps
module host_link_model (
  // Clock and read data
  input wire logic mclk,
  input wire logic [7:0] rdata,
  // Request lines
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [1:0] byte_sel,
  output logic [7:0] wdata
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    byte_sel = 2'h0;
    wdata = 8'h00;
  end

  // One-cycle write pulse; released addr and wdata show the inverse, byte_sel keeps its value
  task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [7:0] d);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= a;
    byte_sel <= b;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // Tally path answers two cycles late; lines change only on edges, data taken settled
  task automatic rd(input logic [7:0] a, input logic [1:0] b, output logic [7:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr <= a;
    byte_sel <= b;
    @(posedge mclk);
    rd_stb <= 1'b0;
    repeat (2) @(posedge mclk);
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

// file: channel_disable_and_accumulation_tally_test.sv
// Self-checking bench for the channel mask and accumulation tally registers.
// Assumes the host model drives the byte port; converter inputs driven here.
`timescale 1ns/1ps
module channel_disable_and_accumulation_tally_test;
  import chan_mask_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ptr_step = 1'b0;
  logic no_skip = 1'b0;
  logic power_summed = 1'b0;
  logic wr_stb, rd_stb, fast_sel, acc_clear, data_ready;
  logic [7:0] addr, wdata, rdata, ptr_next, rv;
  logic [1:0] byte_sel;
  logic [3:0] chan_active, sample_mode;
  int miscompares = 0;
  int tests_run = 0;
  int n;

  always #5 mclk = ~mclk;

  host_link_model host_link_model_i (.mclk(mclk), .rdata(rdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .addr(addr), .byte_sel(byte_sel), .wdata(wdata));

  // Three-channel part, short settle so the refresh wait stays brief
  chan_mask_regs #(.FITTED_MASK(4'h1), .SETTLE_CYC(8)) chan_mask_regs_i (
    .mclk(mclk), .arst_n(arst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr),
    .byte_sel(byte_sel), .wdata(wdata), .rdata(rdata), .ptr_step(ptr_step),
    .no_skip(no_skip), .ptr_next(ptr_next), .power_summed(power_summed),
    .chan_active(chan_active), .sample_mode(sample_mode), .fast_sel(fast_sel),
    .acc_clear(acc_clear), .data_ready(data_ready));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step_ptr();
    @(posedge mclk) ptr_step <= 1'b1;
    @(posedge mclk) ptr_step <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Reset value and mask bit order
    host_link_model_i.rd(OFF_CTRL, 2'h0, rv);
    chk("ctrl_lo_reset", 8'h10, rv);
    host_link_model_i.rd(OFF_CTRL, 2'h1, rv);
    chk("ctrl_hi_reset", 8'h07, rv);
    chk("active_reset", 8'h07, {4'h0, chan_active});
    // Channel 2 off; low nibble writes are dropped
    host_link_model_i.wr(OFF_CTRL, 2'h0, 8'h4F);
    host_link_model_i.rd(OFF_CTRL, 2'h0, rv);
    chk("ctrl_lo", 8'h40, rv);
    chk("active_ch2_off", 8'h0D, {4'h0, chan_active});
    // Mode field, mask kept in single-shot modes
    for (int i = 8; i < 12; i++) begin
      host_link_model_i.wr(OFF_CTRL, 2'h1, {i[3:0], 4'h7});
      @(posedge mclk);
      #1;
      chk("mode", {4'h0, i[3:0]}, {4'h0, sample_mode});
      chk("fast", {7'h0, i[3:0] >= MODE_FAST}, {7'h0, fast_sel});
      chk("active_mode", 8'h0D, {4'h0, chan_active});
    end
    // Sleep converts nothing, so no channel is active
    host_link_model_i.wr(OFF_CTRL, 2'h1, {MODE_SLEEP, 4'h7});
    @(posedge mclk);
    #1;
    chk("active_sleep", 8'h00, {4'h0, chan_active});
    // Pointer skips channel 2 result address unless no-skip is set
    host_link_model_i.wr(OFF_CH_FIRST, 2'h0, 8'h00);
    step_ptr();
    chk("ptr_skip", 8'h05, ptr_next);
    @(posedge mclk) no_skip <= 1'b1;
    host_link_model_i.wr(OFF_CH_FIRST, 2'h0, 8'h00);
    step_ptr();
    chk("ptr_noskip", 8'h04, ptr_next);
    // Three summed results, then refresh snapshots and clears
    repeat (3) begin
      @(posedge mclk) power_summed <= 1'b1;
      @(posedge mclk) power_summed <= 1'b0;
    end
    host_link_model_i.wr(OFF_REFRESH, 2'h0, 8'h00);
    #1;
    chk("acc_clear", 8'h01, {7'h0, acc_clear});
    chk("ready_low", 8'h00, {7'h0, data_ready});
    n = 0;
    while (data_ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("settle", 8'h08, n[7:0]);
    host_link_model_i.rd(OFF_TALLY, 2'h0, rv);
    chk("tally_b0", 8'h03, rv);
    host_link_model_i.rd(OFF_TALLY, 2'h3, rv);
    chk("tally_b3", 8'h00, rv);
    // Host-written tally shows after the next refresh, which drops ready again
    host_link_model_i.wr(OFF_TALLY, 2'h1, 8'h5A);
    host_link_model_i.wr(OFF_REFRESH, 2'h0, 8'h00);
    #1;
    chk("ready_drop", 8'h00, {7'h0, data_ready});
    host_link_model_i.rd(OFF_TALLY, 2'h1, rv);
    chk("tally_b1", 8'h5A, rv);
    wrap_up();
  end
endmodule
